// [usp_pkg.sv]
// shared constants for the half-duplex serial port
package usp_pkg;
  // register indices and byte addresses (index times four)
  localparam logic [7:0]  USP_DATA_IDX  = 8'hd6;
  localparam logic [7:0]  USP_CTRL_IDX  = 8'hd7;
  localparam logic [11:0] USP_DATA_ADDR = {2'h0, USP_DATA_IDX, 2'h0};
  localparam logic [11:0] USP_CTRL_ADDR = {2'h0, USP_CTRL_IDX, 2'h0};
  // control register field positions
  localparam int USP_RECEIVE_READY_FLAG_BIT = 7;
  localparam int USP_TRANSMITTER_EMPTY_FLAG_BIT  = 6;
  localparam int USP_RECEIVE_IRQ_ENABLE_BIT = 5;
  localparam int USP_TRANSMIT_IRQ_ENABLE_BIT = 4;
  localparam int USP_BAUD_LSB  = 1;
  localparam int USP_NINTH_BIT = 0;
  // reset values
  localparam logic [2:0] USP_BAUD_RST  = 3'h0;
  localparam logic       USP_NINTH_RST = 1'b0;
  // internal clock divisors per baud code
  localparam logic [12:0] USP_DIV0 = 13'd6656;
  localparam logic [12:0] USP_DIV1 = 13'd3328;
  localparam logic [12:0] USP_DIV2 = 13'd1664;
  localparam logic [12:0] USP_DIV3 = 13'd832;
  localparam logic [12:0] USP_DIV4 = 13'd416;
  localparam logic [12:0] USP_DIV5 = 13'd256;
  localparam logic [12:0] USP_DIV6 = 13'd208;
  // states per bit, sample phases, character length
  localparam int         USP_OVERSAMPLE = 8;
  localparam logic [2:0] USP_PH_LAST    = 3'h7;
  localparam logic [2:0] USP_PH_S0      = 3'h3;
  localparam logic [2:0] USP_PH_S1      = 3'h4;
  localparam logic [2:0] USP_PH_S2      = 3'h5;
  localparam logic [3:0] USP_LAST_BIT   = 4'ha;
  localparam logic [3:0] USP_LAST_DATA  = 4'h9;
  // shared transmit/receive sequencer states, gray along idle-tx / idle-rx
  typedef enum logic [1:0] {
    USP_IDLE = 2'b00,
    USP_TX   = 2'b01,
    USP_RX   = 2'b10
  } usp_state_t;
endpackage

// [usp_tick_if.sv]
// carrier for the oversampling tick and bit phase
`timescale 1ns/1ns
`default_nettype none
interface usp_tick_if;
  logic       tick;
  logic [2:0] phase;
  modport src (output tick, input phase);
  modport snk (input tick, input phase);
endinterface
`default_nettype wire

// [usp_baud_gen.sv]
// baud divider giving a tick at eight times the bit rate
`timescale 1ns/1ns
`default_nettype none
module usp_baud_gen
  import usp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [2:0] baud_select,
  usp_tick_if.src         tk
);
  logic [9:0] cnt_r;
  logic [9:0] lim;
  logic       tick_r;

  // per-tick limit is the divisor over eight, minus one
  always_comb begin
    case (baud_select)
      3'h0:    lim = USP_DIV0[12:3] - 10'h1;
      3'h1:    lim = USP_DIV1[12:3] - 10'h1;
      3'h2:    lim = USP_DIV2[12:3] - 10'h1;
      3'h3:    lim = USP_DIV3[12:3] - 10'h1;
      3'h4:    lim = USP_DIV4[12:3] - 10'h1;
      3'h5:    lim = USP_DIV5[12:3] - 10'h1;
      3'h6:    lim = USP_DIV6[12:3] - 10'h1;
      default: lim = 10'h3ff; // reserved code: tick stalls
    endcase
  end

  // divisor from select, no latching so a change acts at once
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r  <= 10'h0;
      tick_r <= 1'b0;
    end else if (baud_select == 3'h7) begin
      cnt_r  <= 10'h0;
      tick_r <= 1'b0;
    end else if (cnt_r >= lim) begin
      cnt_r  <= 10'h0;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 10'h1;
      tick_r <= 1'b0;
    end
  end
  assign tk.tick = tick_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_tick_spacing: assert property (tick_r && baud_select == 3'h6 && $stable(baud_select) |=> !tick_r [*8])
    else $error("baud ticks too close for code 6");
endmodule // usp_baud_gen
`default_nettype wire

// [usp_vote.sv]
// three-sample majority voter for the receive line
`timescale 1ns/1ns
`default_nettype none
module usp_vote
  import usp_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic rx,
  usp_tick_if.snk   tk,
  output logic      vote
);
  logic [2:0] smp_r;

  // capture at three mid-bit phases; edges fall in the unsampled states
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      smp_r <= 3'h7;
    end else if (tk.tick) begin
      if (tk.phase == USP_PH_S0) smp_r[0] <= rx;
      if (tk.phase == USP_PH_S1) smp_r[1] <= rx;
      if (tk.phase == USP_PH_S2) smp_r[2] <= rx;
    end
  end

  assign vote = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2]) | (smp_r[1] & smp_r[2]);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_vote_major: assert property (smp_r[0] == smp_r[1] |-> vote == smp_r[0])
    else $error("majority vote wrong");
endmodule // usp_vote
`default_nettype wire

// [usp_serial_port.sv]
// half-duplex nine-bit serial port with apb register access
`timescale 1ns/1ns
`default_nettype none
module usp_serial_port
  import usp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_pin,
  input  wire logic              port_data,
  output logic                   serial_out_pin,
  output logic                   serial_output_select,
  output logic                   irq
);
  usp_tick_if tk ();

  usp_state_t  st_r;
  logic [2:0]  phase_r;
  logic [3:0]  bit_cnt_r;
  logic [10:0] tx_shift_r;
  logic [8:0]  rx_shift_r;
  logic [7:0]  rx_buf_r;
  logic        rx_s1_r;
  logic        rx_s2_r;
  logic        rx_d_r;
  logic        vote;
  logic        receive_ready_flag_r;
  logic        transmitter_empty_flag_r;
  logic        receive_irq_enable_r;
  logic        transmit_irq_enable_r;
  logic [2:0]  baud_select_r;
  logic        ninth_bit_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        pin_r;
  logic        irq_r;
  logic        acc;
  logic        wr_data;
  logic        wr_ctrl;
  logic        hit_data;
  logic        hit_ctrl;
  logic        bit_end;
  logic        tx_done;
  logic        rx_done;
  logic        rx_fall;

  // single internal clock drives divider and sequencer alike
  usp_baud_gen u_baud (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .baud_select (baud_select_r),
    .tk          (tk)
  );

  usp_vote u_vote (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .rx      (rx_s2_r),
    .tk      (tk),
    .vote    (vote)
  );
  assign tk.phase = phase_r;

  // apb decode; completion is the access cycle with pready high
  // writes commit only on that cycle, so a stalled master never writes twice
  assign hit_data = (paddr == USP_DATA_ADDR[ADDR_W-1:0]);
  assign hit_ctrl = (paddr == USP_CTRL_ADDR[ADDR_W-1:0]);
  assign acc      = psel & penable & pready_r;
  assign wr_data  = acc & pwrite & hit_data;
  assign wr_ctrl  = acc & pwrite & hit_ctrl;

  // sequencer events
  // frame length is counted in bit ends, so a baud change alters the length of the bit in progress and all later bits
  assign bit_end = tk.tick & (phase_r == USP_PH_LAST);
  assign tx_done = (st_r == USP_TX) & bit_end & (bit_cnt_r == USP_LAST_BIT);
  assign rx_done = (st_r == USP_RX) & bit_end & (bit_cnt_r == USP_LAST_BIT);
  assign rx_fall = rx_d_r & ~rx_s2_r;

  // receive pin synchroniser plus one stage for edge detect
  // rx_s1_r feeds nothing but rx_s2_r, keeping metastability out of the voter
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_d_r  <= 1'b1;
    end else begin
      rx_s1_r <= rx_pin;
      rx_s2_r <= rx_s1_r;
      rx_d_r  <= rx_s2_r;
    end
  end

  // one wait state, so read data can come from a flop
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~hit_data & ~hit_ctrl;
      if (psel & penable & ~pready_r & ~pwrite) begin
        // data read gives the receive buffer
        // control layout; bit 0 reads the ninth bit, last received or last written
        if (hit_data) begin
          prdata_r <= {24'h0, rx_buf_r};
        end else if (hit_ctrl) begin
          prdata_r <= {24'h0, receive_ready_flag_r, transmitter_empty_flag_r,
                       receive_irq_enable_r, transmit_irq_enable_r,
                       baud_select_r, ninth_bit_r};
        end else begin
          prdata_r <= 32'h0;
        end
      end else begin
        prdata_r <= 32'h0;
      end
    end
  end

  // control bits written by software
  // baud field goes straight to the divider, mid-character too
  // no latching of the code: software must keep it still during a frame
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      receive_irq_enable_r  <= 1'b0;
      transmit_irq_enable_r <= 1'b0;
      baud_select_r         <= USP_BAUD_RST;
    end else if (wr_ctrl) begin
      receive_irq_enable_r  <= pwdata[USP_RECEIVE_IRQ_ENABLE_BIT];
      transmit_irq_enable_r <= pwdata[USP_TRANSMIT_IRQ_ENABLE_BIT];
      baud_select_r         <= pwdata[USP_BAUD_LSB +: 3];
    end
  end

  // empty flag: hardware set wins over any clear
  // a data write meeting the end of a frame still leaves the flag set
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      transmitter_empty_flag_r <= 1'b0;
    end else if (tx_done) begin
      transmitter_empty_flag_r <= 1'b1;
    end else if (wr_data) begin
      transmitter_empty_flag_r <= 1'b0;
    end else if (wr_ctrl) begin
      transmitter_empty_flag_r <= pwdata[USP_TRANSMITTER_EMPTY_FLAG_BIT];
    end
  end

  // ready flag: zero write clears, one write sets, arrival wins
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      receive_ready_flag_r <= 1'b0;
    end else if (rx_done) begin
      receive_ready_flag_r <= 1'b1;
    end else if (wr_ctrl) begin
      receive_ready_flag_r <= pwdata[USP_RECEIVE_READY_FLAG_BIT];
    end
  end

  // ninth bit holds until rewritten or a character arrives
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ninth_bit_r <= USP_NINTH_RST;
    end else if (rx_done) begin
      ninth_bit_r <= rx_shift_r[8];
    end else if (wr_ctrl) begin
      ninth_bit_r <= pwdata[USP_NINTH_BIT];
    end
  end

  // buffer is loaded only at character end, so the shifter stays free
  // transfer after the stop bit time
  // only eight bits kept here; the ninth goes to the control register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_buf_r <= 8'h0;
    end else if (rx_done) begin
      rx_buf_r <= rx_shift_r[7:0];
    end
  end

  // shared sequencer: one bit counter and phase serve both directions
  // reset drops any frame and returns to idle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r       <= USP_IDLE;
      phase_r    <= 3'h0;
      bit_cnt_r  <= 4'h0;
      tx_shift_r <= 11'h7ff;
      rx_shift_r <= 9'h0;
    end else if (wr_data) begin
      // frame built as stop, ninth, data lsb first, start
      st_r       <= USP_TX;
      phase_r    <= 3'h0;
      bit_cnt_r  <= 4'h0;
      tx_shift_r <= {1'b1, ninth_bit_r, pwdata[7:0], 1'b0};
    end else begin
      case (st_r)
        USP_IDLE: begin
          // watch for a falling edge only while not transmitting
          // edge detector runs during tx too, so a line left low is no edge
          if (rx_fall) begin
            st_r      <= USP_RX;
            phase_r   <= 3'h0;
            bit_cnt_r <= 4'h0;
          end
        end
        USP_TX: begin
          if (tk.tick) phase_r <= phase_r + 3'h1;
          if (bit_end) begin
            // after the stop bit the pin goes back to port control
            if (bit_cnt_r == USP_LAST_BIT) begin
              st_r <= USP_IDLE;
            end else begin
              bit_cnt_r  <= bit_cnt_r + 4'h1;
              tx_shift_r <= {1'b1, tx_shift_r[10:1]};
            end
          end
        end
        USP_RX: begin
          if (tk.tick) phase_r <= phase_r + 3'h1;
          if (bit_end) begin
            // bit 0 is the start bit, skipped
            // voted value shifted in lsb first
            if (bit_cnt_r != 4'h0 && bit_cnt_r <= USP_LAST_DATA) begin
              rx_shift_r <= {vote, rx_shift_r[8:1]};
            end
            if (bit_cnt_r == USP_LAST_BIT) begin
              st_r <= USP_IDLE;
            end else begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        default: st_r <= USP_IDLE;
      endcase
    end
  end

  // shifter bit goes out inverted
  // limitation: outside a frame the pin is raw port data, not inverted
  // port data passes through when the serial path is off
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_r <= 1'b0;
    end else if (st_r == USP_TX) begin
      pin_r <= ~tx_shift_r[0];
    end else begin
      pin_r <= port_data;
    end
  end

  // each source gated by its own enable
  // registered so the level cannot glitch while flags and enables settle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (transmitter_empty_flag_r & transmit_irq_enable_r) |
               (receive_ready_flag_r & receive_irq_enable_r);
    end
  end

  assign prdata               = prdata_r;
  assign pready               = pready_r;
  assign pslverr              = pslverr_r;
  assign serial_out_pin       = pin_r;
  // tx is the only state with bit 0 set, so select is a bare state flop bit
  assign serial_output_select = st_r[0];
  assign irq                  = irq_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // checks on the sequencer, flags, output pin and interrupt
  a_tx_start_load: assert property (wr_data && !tx_done |=>
    st_r == USP_TX && !transmitter_empty_flag_r && bit_cnt_r == 4'h0)
    else $error("data write did not start transmission");
  a_start_bit_inv: assert property (st_r == USP_TX && bit_cnt_r == 4'h0 |=> serial_out_pin)
    else $error("start bit not driven inverted");
  a_port_follow: assert property (st_r != USP_TX |=> serial_out_pin == $past(port_data))
    else $error("pin does not follow port data");
  a_tx_end_flag: assert property (tx_done && !wr_data |=> transmitter_empty_flag_r && !serial_output_select)
    else $error("end of transmission not flagged");
  a_rx_abort: assert property (st_r == USP_RX && wr_data |=> st_r == USP_TX)
    else $error("reception not aborted by transmit");
  a_rx_buffer: assert property (rx_done |=> receive_ready_flag_r && rx_buf_r == $past(rx_shift_r[7:0]))
    else $error("received character not buffered");
  a_ninth_hold: assert property (!rx_done && !wr_ctrl |=> $stable(ninth_bit_r))
    else $error("ninth bit changed without cause");
  a_irq_gate: assert property (!transmit_irq_enable_r && !receive_irq_enable_r |=> !irq)
    else $error("interrupt raised while disabled");
  a_rx_edge_start: assert property (st_r == USP_IDLE && rx_fall && !wr_data |=> st_r == USP_RX)
    else $error("falling edge did not start reception");
  a_bit_phase: assert property (st_r == USP_TX && !tk.tick && !wr_data |=> $stable(phase_r))
    else $error("phase moved without a tick");

  // stop bit level, ninth bit capture and bus pulse shape
  a_stop_level: assert property (st_r == USP_TX && bit_cnt_r == USP_LAST_BIT |=> !serial_out_pin)
    else $error("stop bit not driven");
  a_rx_ninth: assert property (rx_done |=> ninth_bit_r == $past(rx_shift_r[8]))
    else $error("received ninth bit not kept");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
endmodule // usp_serial_port
`default_nettype wire

// [usp_line_peer.sv]
// remote serial peer: drives the receive line and decodes the transmit line
`timescale 1ns/1ns
`default_nettype none
module usp_line_peer #(
  parameter int BIT_CLKS = 208
) (
  input  wire logic sys_clk,
  input  wire logic tx_line,
  input  wire logic tx_sel,
  output logic      rx_line
);
  // idle line rests at the stop level
  initial rx_line = 1'b1;

  // start, nine bits lsb first, stop; parity is the caller's job
  task automatic send(input logic [8:0] ch);
    logic [10:0] fr;
    fr = {1'b1, ch, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge sys_clk);
      rx_line <= fr[i];
      repeat (BIT_CLKS - 1) @(posedge sys_clk);
    end
  endtask

  // line is inverted, so each mid-bit sample is flipped back
  task automatic capture(output logic [10:0] fr, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    fr = '0;
    while (tx_sel !== 1'b1 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n < 4000) begin
      ok = 1'b1;
      // mid-bit sampling tolerates the short first bit
      repeat (BIT_CLKS / 2) @(posedge sys_clk);
      for (int i = 0; i < 11; i++) begin
        fr[i] = ~tx_line;
        repeat (BIT_CLKS) @(posedge sys_clk);
      end
    end
  endtask
endmodule // usp_line_peer
`default_nettype wire

// [usp_serial_port_tb.sv]
// self-checking bench for the half-duplex serial port
`timescale 1ns/1ns
`default_nettype none
module usp_serial_port_tb
  import usp_pkg::*;
();
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_pin;
  // port bit held high so the idle line sits at the inverted start bit level, not the stop level
  logic        port_data = 1'b1;
  logic        serial_out_pin;
  logic        serial_output_select;
  logic        irq;
  int          mismatches = 0;
  int          checked = 0;
  logic [10:0] fr;
  logic        ok;
  int          n;

  // 10 MHz system clock
  always #50 sys_clk = ~sys_clk;

  usp_serial_port #(.ADDR_W(12)) u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pin(rx_pin), .port_data(port_data), .serial_out_pin(serial_out_pin),
    .serial_output_select(serial_output_select), .irq(irq));

  usp_line_peer #(.BIT_CLKS(208)) u_peer (
    .sys_clk(sys_clk), .tx_line(serial_out_pin), .tx_sel(serial_output_select), .rx_line(rx_pin));

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      check("pready", 32'h1, 32'h0);
      conclude();
    end
  endtask

  // data register gets plain writes only, never read-modify-write
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, {24'h0, d}, rd, err);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check(what, {24'h0, exp}, rd);
  endtask

  // bounded wait for the output select level, returns cycles spent
  task automatic wait_sel(input logic lvl, output int cnt);
    cnt = 0;
    while (serial_output_select !== lvl && cnt < 5000) begin
      @(posedge sys_clk);
      cnt++;
    end
    if (cnt >= 5000) begin
      check("select wait", {31'h0, lvl}, {31'h0, ~lvl});
      conclude();
    end
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 4000) begin
      @(posedge sys_clk);
      k++;
    end
    check("irq wait", 32'h1, {31'h0, irq});
    if (irq !== 1'b1) conclude();
  endtask

  task automatic t_reset();
    logic [31:0] rd;
    logic        err;
    rd_chk("ctrl reset", USP_CTRL_ADDR, 8'h00);
    check("select reset", 32'h0, {31'h0, serial_output_select});
    apb(1'b0, 12'h000, 32'h0, rd, err);
    check("unmapped err", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    $display("test reset done");
  endtask

  task automatic t_port();
    port_data <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("pin follows 0", 32'h0, {31'h0, serial_out_pin});
    port_data <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("pin follows 1", 32'h1, {31'h0, serial_out_pin});
    $display("test port done");
  endtask

  task automatic t_tx();
    wr(USP_CTRL_ADDR, 8'h1d);
    wr(USP_DATA_ADDR, 8'ha5);
    // peer decodes while the bench times the frame
    fork
      u_peer.capture(fr, ok);
      begin
        wait_sel(1'b1, n);
        wait_sel(1'b0, n);
      end
    join
    check("capture ok", 32'h1, {31'h0, ok});
    check("tx frame", {21'h0, 11'h74a}, {21'h0, fr});
    check("frame 208", 32'h1, {31'h0, (n >= 2262 && n <= 2290)});
    repeat (3) @(posedge sys_clk);
    check("tx irq", 32'h1, {31'h0, irq});
    rd_chk("ctrl after tx", USP_CTRL_ADDR, 8'h5d);
    wr(USP_CTRL_ADDR, 8'h1d);
    repeat (3) @(posedge sys_clk);
    check("empty cleared", 32'h0, {31'h0, irq});
    wr(USP_CTRL_ADDR, 8'h5b);
    repeat (3) @(posedge sys_clk);
    check("empty by software", 32'h1, {31'h0, irq});
    wr(USP_DATA_ADDR, 8'h3c);
    rd_chk("empty by data", USP_CTRL_ADDR, 8'h1b);
    wait_sel(1'b1, n);
    wait_sel(1'b0, n);
    check("frame 256", 32'h1, {31'h0, (n >= 2782 && n <= 2813)});
    $display("test tx done");
  endtask

  task automatic t_rx();
    wr(USP_CTRL_ADDR, 8'h2c);
    u_peer.send(9'h13c);
    wait_irq();
    rd_chk("rx data", USP_DATA_ADDR, 8'h3c);
    rd_chk("rx ctrl", USP_CTRL_ADDR, 8'had);
    wr(USP_CTRL_ADDR, 8'h2c);
    repeat (3) @(posedge sys_clk);
    check("ready cleared", 32'h0, {31'h0, irq});
    fork
      u_peer.send(9'h0c3);
      begin
        repeat (1000) @(posedge sys_clk);
        rd_chk("buffer held", USP_DATA_ADDR, 8'h3c);
      end
    join
    wait_irq();
    rd_chk("rx data 2", USP_DATA_ADDR, 8'hc3);
    rd_chk("rx ctrl 2", USP_CTRL_ADDR, 8'hac);
    $display("test rx done");
  endtask

  task automatic t_abort();
    wr(USP_CTRL_ADDR, 8'h2c);
    fork
      u_peer.send(9'h055);
      begin
        repeat (624) @(posedge sys_clk);
        wr(USP_DATA_ADDR, 8'h0f);
      end
    join
    wait_sel(1'b0, n);
    repeat (3) @(posedge sys_clk);
    check("abort irq", 32'h0, {31'h0, irq});
    rd_chk("abort ctrl", USP_CTRL_ADDR, 8'h6c);
    $display("test abort done");
  endtask

  // main sequence after four reset cycles
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    t_port();
    t_tx();
    t_rx();
    t_abort();
    conclude();
  end
endmodule // usp_serial_port_tb
`default_nettype wire
